// ### rtl/mspi_master.sv
// serial transceiver in master serial peripheral mode: clock, shifter, buffers
module mspi_master
	import mspi_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// configuration
	input  wire logic [1:0] operating_mode_select,
	input  wire logic       clock_polarity_bit,
	input  wire logic       clock_phase_bit,
	input  wire logic       bit_order_select,
	input  wire logic       transmitter_enable_bit,
	input  wire logic       receiver_enable_bit,
	input  wire logic [3:0] baud_divider_high,
	input  wire logic [7:0] baud_divider_low,
	input  wire logic       baud_high_write,
	input  wire logic       baud_low_write,
	// transmit data
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_write,
	output logic            data_register_empty,
	// receive data
	output logic [7:0]      rx_data,
	input  wire logic       rx_read,
	// status
	output logic            transmit_complete_flag,
	input  wire logic       transmit_complete_clear,
	output logic            receive_complete_flag,
	output logic            frame_error,
	output logic            data_overrun,
	output logic            parity_error,
	// pins
	output logic            transfer_clock_pin,
	output logic            serial_out_pin,
	output logic            serial_out_oe_n,
	input  wire logic       serial_in_pin,
	output logic            serial_in_active
);
	logic [11:0]   baud_divider;
	logic [11:0]   next_baud_divider;
	logic          serial_master_peripheral_mode;
	logic          tx_on;
	logic          rx_on;
	logic          tick;
	xfer_state_t   state;
	xfer_state_t   next_state;
	logic [7:0]    shifter;
	logic [7:0]    next_shifter;
	logic [3:0]    bit_cnt;
	logic [3:0]    next_bit_cnt;
	logic          sck;
	logic          next_sck;
	logic          sdo;
	logic          next_sdo;
	logic          sample;
	logic          next_sample;
	logic [7:0]    tx_buf;
	logic [7:0]    next_tx_buf;
	logic          tx_full;
	logic          next_tx_full;
	logic          txc;
	logic          next_txc;
	logic [7:0]    rx_mem [RX_DEPTH];
	logic [7:0]    next_rx_mem [RX_DEPTH];
	logic [1:0]    rx_cnt;
	logic [1:0]    next_rx_cnt;
	logic          load;
	logic          frame_done;
	logic [7:0]    rx_byte;

	assign serial_master_peripheral_mode = (operating_mode_select == MODE_SERIAL_MSTR);
	assign tx_on = serial_master_peripheral_mode && transmitter_enable_bit;
	assign rx_on = tx_on && receiver_enable_bit;

	assign frame_error  = 1'b0;
	assign data_overrun = 1'b0;
	assign parity_error = 1'b0;

	always_comb begin
		next_baud_divider = baud_divider;
		if (baud_high_write) begin
			next_baud_divider[11:8] = baud_divider_high;
		end
		if (baud_low_write) begin
			next_baud_divider[7:0] = baud_divider_low;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_divider <= DIV_RESET;
		end else begin
			baud_divider <= next_baud_divider;
		end
	end

	baud_gen #(
		.W (DIV_BITS)
	) u_baud (
		.clk     (clk),
		.rst_n   (rst_n),
		.run     (state != ST_IDLE),
		.divider (baud_divider),
		.tick    (tick)
	);

	// shifter takes buffered byte when free
	assign load = tx_on && tx_full && (state == ST_IDLE);
	assign frame_done = tick && (state == ST_TRAIL) && (bit_cnt == LAST_BIT);
	assign rx_byte = next_shifter;

	always_comb begin
		next_state   = state;
		next_shifter = shifter;
		next_bit_cnt = bit_cnt;
		next_sck     = sck;
		next_sdo     = sdo;
		next_sample  = sample;
		case (state)
			ST_IDLE: begin
				next_sck = clock_polarity_bit;
				if (load) begin
					next_shifter = tx_buf;
					next_bit_cnt = '0;
					next_state   = ST_LEAD;
					next_sdo     = bit_order_select ? tx_buf[0] : tx_buf[7];
				end else begin
					// line idles high: on the last edge in phase 0, one cycle after it in phase 1
					next_sdo     = 1'b1;
				end
			end
			ST_LEAD: begin
				if (tick) begin
					next_sck   = ~clock_polarity_bit;
					next_state = ST_TRAIL;
					if (!clock_phase_bit) begin
						next_sample = serial_in_pin;
					end else if (bit_cnt != '0) begin
						next_sdo = bit_order_select ? shifter[0] : shifter[7];
					end
				end
			end
			ST_TRAIL: begin
				if (tick) begin
					next_sck = clock_polarity_bit;
					if (bit_order_select) begin
						next_shifter = {(clock_phase_bit ? serial_in_pin : sample), shifter[7:1]};
					end else begin
						next_shifter = {shifter[6:0], (clock_phase_bit ? serial_in_pin : sample)};
					end
					if (!clock_phase_bit) begin
						next_sdo = bit_order_select ? next_shifter[0] : next_shifter[7];
					end
					next_bit_cnt = bit_cnt + 4'h1;
					next_state   = ST_LEAD;
					if (bit_cnt == LAST_BIT) begin
						next_state = ST_IDLE;
						// phase 1 samples on this edge: keep the last bit for hold
						if (!clock_phase_bit) begin
							next_sdo = 1'b1;
						end
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!tx_on) begin
			next_state = ST_IDLE;
			next_sck   = clock_polarity_bit;
			next_sdo   = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_IDLE;
			shifter <= 8'h00;
			bit_cnt <= 4'h0;
			sck     <= 1'b0;
			sdo     <= 1'b1;
			sample  <= 1'b0;
		end else begin
			state   <= next_state;
			shifter <= next_shifter;
			bit_cnt <= next_bit_cnt;
			sck     <= next_sck;
			sdo     <= next_sdo;
			sample  <= next_sample;
		end
	end

	// transmit buffer and completion; set beats clear on the complete flag
	always_comb begin
		next_tx_buf  = tx_buf;
		next_tx_full = tx_full;
		next_txc     = txc;
		if (load) begin
			next_tx_full = 1'b0;
		end
		if (tx_write && (!tx_full || load)) begin
			next_tx_buf  = tx_data;
			next_tx_full = 1'b1;
		end
		if (transmit_complete_clear) begin
			next_txc = 1'b0;
		end
		if (frame_done && !tx_full && !tx_write) begin
			next_txc = 1'b1;
		end
		if (!tx_on) begin
			next_tx_full = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf  <= 8'h00;
			tx_full <= 1'b0;
			txc     <= 1'b0;
		end else begin
			tx_buf  <= next_tx_buf;
			tx_full <= next_tx_full;
			txc     <= next_txc;
		end
	end

	// receive buffer, two levels; a read pops the oldest
	always_comb begin
		next_rx_cnt = rx_cnt;
		for (int i = 0; i < RX_DEPTH; i++) begin
			next_rx_mem[i] = rx_mem[i];
		end
		if (rx_read && rx_cnt != 2'h0) begin
			next_rx_mem[0] = rx_mem[1];
			next_rx_cnt    = rx_cnt - 2'h1;
		end
		if (frame_done && rx_on && next_rx_cnt != 2'(RX_DEPTH)) begin
			next_rx_mem[next_rx_cnt[0]] = rx_byte;
			next_rx_cnt = next_rx_cnt + 2'h1;
		end
		if (!rx_on) begin
			next_rx_cnt = 2'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt <= 2'h0;
			for (int i = 0; i < RX_DEPTH; i++) begin
				rx_mem[i] <= 8'h00;
			end
		end else begin
			rx_cnt <= next_rx_cnt;
			rx_mem <= next_rx_mem;
		end
	end

	assign data_register_empty    = !tx_full;
	assign transmit_complete_flag = txc;
	assign receive_complete_flag  = (rx_cnt != 2'h0);
	assign rx_data                = rx_mem[0];

	assign transfer_clock_pin = sck;
	assign serial_out_pin     = sdo;
	assign serial_out_oe_n    = !tx_on;
	assign serial_in_active   = rx_on;

	// clock rests at polarity when idle
	AST_CLK_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && $past(state) == ST_IDLE && $stable(clock_polarity_bit))
		|-> transfer_clock_pin == clock_polarity_bit)
		else $error("clock not at idle level");
	AST_RX_NEEDS_TX: assert property (@(posedge clk) disable iff (!rst_n)
		serial_in_active |-> !serial_out_oe_n)
		else $error("receiver active without transmitter");
	AST_ERR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		!(frame_error || data_overrun || parity_error))
		else $error("error flag set");
	AST_WRITE_STARTS: assert property (@(posedge clk) disable iff (!rst_n)
		(tx_on && state == ST_IDLE && tx_full) ##1 tx_on |-> state == ST_LEAD)
		else $error("queued byte not loaded");
	AST_RX_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
		rx_cnt <= 2'(RX_DEPTH))
		else $error("receive buffer overfilled");
	AST_TXC_QUEUE: assert property (@(posedge clk) disable iff (!rst_n)
		(!$past(txc) && txc) |-> !$past(tx_full))
		else $error("complete while byte queued");
	AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		frame_done |-> bit_cnt == LAST_BIT)
		else $error("frame length wrong");
	AST_MODE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
		!serial_master_peripheral_mode ##1 !serial_master_peripheral_mode |-> state == ST_IDLE)
		else $error("active outside mode");
	AST_EDGE_ALT: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_LEAD && tick && tx_on) |=> transfer_clock_pin != clock_polarity_bit)
		else $error("leading edge missing");

	COV_FRAME: cover property (@(posedge clk) disable iff (!rst_n) frame_done);
	COV_CHAIN: cover property (@(posedge clk) disable iff (!rst_n) frame_done && tx_full);
	COV_OVERFLOW: cover property (@(posedge clk) disable iff (!rst_n) frame_done && rx_cnt == 2'h2);
	COV_MODE3: cover property (@(posedge clk) disable iff (!rst_n)
		frame_done && clock_polarity_bit && clock_phase_bit);
endmodule : mspi_master

// ### shared/mspi_pkg.sv
// shared constants and types for the serial master peripheral mode block
package mspi_pkg;
	localparam int          FRAME_BITS        = 8;
	localparam int          DIV_BITS          = 12;
	localparam logic [11:0] DIV_RESET         = 12'h000;
	localparam logic [1:0]  MODE_SERIAL_MSTR  = 2'h3;
	localparam logic [3:0]  LAST_BIT          = 4'h7;
	localparam int          RX_DEPTH          = 2;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LEAD,
		ST_TRAIL
	} xfer_state_t;
endpackage : mspi_pkg

// ### rtl/baud_gen.sv
// half-period tick generator for the transfer clock
module baud_gen
	import mspi_pkg::*;
#(
	parameter int W = DIV_BITS
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// control
	input  wire logic         run,
	input  wire logic [W-1:0] divider,
	// tick
	output logic              tick
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (!run) begin
			next_count = '0;
		end else if (count >= divider) begin
			next_count = '0;
		end else begin
			next_count = count + 1'b1;
		end
	end

	assign tick = run && (count >= divider);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && divider == 12'h001 && $stable(divider)) ##1 run |-> !tick)
		else $error("tick spacing too short");
endmodule : baud_gen

// ### sim/spi_slave_model.sv
// behavioural serial slave facing the master's clock and data pins
module spi_slave_model (
	// pins
	input  wire logic       sclk,
	input  wire logic       mosi,
	output logic            miso,
	// setup from the bench
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       lsb,
	input  wire logic       clr,
	input  wire logic [7:0] reply,
	output logic [7:0]      got
);
	timeunit 1ns;
	timeprecision 1ns;
	int k = 0;
	int s = 0;
	int idx;
	always @(sclk) begin
		if ((sclk != cpol) ^ cpha) begin
			got = lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
			s++;
			if (cpha && s == 8) begin
				k = 0;
				s = 0;
			end
		end else begin
			k++;
			if (!cpha && k == 8) begin
				k = 0;
				s = 0;
			end
		end
	end
	// idle polarity moves the clock pin, so the bench resyncs the counts
	always @(posedge clr) begin
		k = 0;
		s = 0;
	end
	assign idx = cpha ? k - 1 : k;
	// before the first leading edge in phase 1 the line shows a stale inverse
	assign miso = (cpha && k == 0) ? ~reply[lsb ? 0 : 7] : reply[lsb ? idx : 7 - idx];
endmodule : spi_slave_model

// ### sim/testbench.sv
// self-checking bench for the serial master block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  msel = 2'h3;
	logic        cpol = 1'b0;
	logic        cpha = 1'b0;
	logic        lsb = 1'b0;
	logic        txen = 1'b1;
	logic        rxen = 1'b1;
	logic [11:0] div = 12'h000;
	logic        dw = 1'b0;
	logic [7:0]  txd = 8'h00;
	logic        txw = 1'b0;
	logic        rdp = 1'b0;
	logic        tclr = 1'b0;
	logic        clr = 1'b0;
	logic [7:0]  reply = 8'h00;
	logic        dre, txc, rxc, fe, dor, pe, sclk, mosi, oe_n, miso, rxa;
	logic [7:0]  rxd, got;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cycles = 0;

	always #50 clk = ~clk;

	// clock pin direction taken as output
	mspi_master dut_u (
		.clk(clk),
		.rst_n(rst_n),
		.operating_mode_select(msel),
		.clock_polarity_bit(cpol),
		.clock_phase_bit(cpha),
		.bit_order_select(lsb),
		.transmitter_enable_bit(txen),
		.receiver_enable_bit(rxen),
		.baud_divider_high(div[11:8]),
		.baud_divider_low(div[7:0]),
		.baud_high_write(dw),
		.baud_low_write(dw),
		.tx_data(txd),
		.tx_write(txw),
		.data_register_empty(dre),
		.rx_data(rxd),
		.rx_read(rdp),
		.transmit_complete_flag(txc),
		.transmit_complete_clear(tclr),
		.receive_complete_flag(rxc),
		.frame_error(fe),
		.data_overrun(dor),
		.parity_error(pe),
		.transfer_clock_pin(sclk),
		.serial_out_pin(mosi),
		.serial_out_oe_n(oe_n),
		.serial_in_pin(miso),
		.serial_in_active(rxa)
	);

	spi_slave_model slave_u (
		.sclk(sclk),
		.mosi(mosi),
		.miso(miso),
		.cpol(cpol),
		.cpha(cpha),
		.lsb(lsb),
		.clr(clr),
		.reply(reply),
		.got(got)
	);

	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic close_out;
		$display("mismatches %0d, checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic setdiv(input logic [11:0] d);
		div = d;
		dw = 1'b1;
		@(negedge clk);
		dw = 1'b0;
	endtask : setdiv

	// clears the complete flag before a write and resyncs the slave
	// clear flag before write
	task automatic prep;
		tclr = 1'b1;
		clr = 1'b1;
		@(negedge clk);
		tclr = 1'b0;
		clr = 1'b0;
	endtask : prep

	task automatic wr(input logic [7:0] b);
		int i;
		for (i = 0; i < 400 && dre !== 1'b1; i++)
			@(negedge clk);
		txd = b;
		txw = 1'b1;
		@(negedge clk);
		txw = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] want);
		check(rxd, want);
		rdp = 1'b1;
		@(negedge clk);
		rdp = 1'b0;
		@(negedge clk);
	endtask : rd

	task automatic wait_rx(input int lim);
		int i;
		for (i = 0; i < lim && rxc !== 1'b1; i++)
			@(negedge clk);
	endtask : wait_rx

	task automatic wait_txc;
		int i;
		for (i = 0; i < 5000 && txc !== 1'b1; i++)
			@(negedge clk);
	endtask : wait_txc

	// counts system cycles of the first active half period
	task automatic half(input int want);
		int n;
		for (n = 0; n < 300 && sclk === cpol; n++)
			@(negedge clk);
		for (n = 0; n < 300 && sclk !== cpol; n++)
			@(negedge clk);
		check(12'(n), 12'(want));
	endtask : half

	task automatic t_reset;
		check({fe, dor, pe, txc, rxc, dre, sclk, mosi}, 12'h005);
		check({oe_n, rxa}, 12'h001);
	endtask : t_reset

	task automatic t_modes;
		int m;
		logic [7:0] b;
		for (m = 0; m < 8; m++) begin
			cpol = m[2];
			cpha = m[1];
			lsb = m[0];
			// divider zero at enable, set later
			if (m > 0)
				setdiv(12'(m % 3));
			repeat (3) @(negedge clk);
			check(sclk, cpol);
			b = 8'h1d + 8'(m * 37);
			reply = b ^ 8'hc3;
			prep();
			wr(b);
			half(m % 3 + 1);
			wait_rx(400);
			check(got, b);
			rd(reply);
			check(mosi, 1'b1);
		end
	endtask : t_modes

	task automatic t_bigdiv;
		setdiv(12'h101);
		prep();
		wr(8'ha5);
		half(258);
		wait_rx(5000);
		rd(reply);
		setdiv(12'h001);
	endtask : t_bigdiv

	task automatic t_pair;
		reply = 8'h96;
		prep();
		wr(8'h4b);
		wr(8'hd2);
		wait_rx(400);
		check(txc, 1'b0);
		wait_txc();
		check(txc, 1'b1);
		check(got, 8'hd2);
		rd(8'h96);
		rd(8'h96);
	endtask : t_pair

	task automatic t_over;
		int i;
		for (i = 0; i < 3; i++) begin
			reply = 8'h30 + 8'(i);
			prep();
			wr(8'h60 + 8'(i));
			wait_txc();
		end
		rd(8'h30);
		rd(8'h31);
		check(rxc, 1'b0);
	endtask : t_over

	task automatic t_alone;
		rxen = 1'b0;
		@(negedge clk);
		check(rxa, 1'b0);
		prep();
		wr(8'h77);
		wait_txc();
		check({txc, rxc}, 12'h002);
		check(got, 8'h77);
		rxen = 1'b1;
	endtask : t_alone

	task automatic t_nomode;
		msel = 2'h1;
		prep();
		wr(8'h55);
		repeat (40) @(negedge clk);
		check({sclk, txc}, {cpol, 1'b0});
	endtask : t_nomode

	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_modes();
		t_bigdiv();
		t_pair();
		t_over();
		t_alone();
		t_nomode();
		close_out();
	end
endmodule : testbench
